// *** core/svm_pkg.sv ***
// How it works
// - aux values: beta, half(beta+r3a), half(beta-r3a)
// - sectors 1-3 pick ratio pairs from aux values
// - sectors 4-6 pick negated/plain aux pairs
// - sector refs: beta, half(-beta+/-r3a)
// - sector tree, three sign tests at most
// - refs +,+,- give sector one
// - low=(T-r1-r2)/2, mid=low+r1, high=mid+r2
// - sectors 1-3 route times to phases A,B,C
// - sectors 4-6 route times to phases A,B,C
package svm_pkg;

  // ----------------------------------------
  // widths and number format
  // ----------------------------------------
  localparam int IW = 16;  // alpha/beta, signed q15
  localparam int PW = 16;  // switching period in pwm counts
  localparam int DW = 18;  // internal signed width
  localparam int FW = 17;  // clamped ratio, 0..1.0 in q15
  localparam int FRAC_SHIFT = 15;
  localparam int SQRT3_SHIFT = 14;
  localparam logic signed [16:0] SQRT3_Q14 = 17'sh06eda;
  localparam logic [FW-1:0] FRAC_ONE = 17'h08000;
  localparam int LATENCY = 4;

  // ----------------------------------------
  // sectors, counterclockwise from zero degrees
  // ----------------------------------------
  typedef enum logic [2:0] {
    SVM_SEC_NONE = 3'h0,
    SVM_SEC_1    = 3'h1,
    SVM_SEC_2    = 3'h2,
    SVM_SEC_3    = 3'h3,
    SVM_SEC_4    = 3'h4,
    SVM_SEC_5    = 3'h5,
    SVM_SEC_6    = 3'h6
  } svm_sector_t;

endpackage

// *** core/svm_sec_if.sv ***
`timescale 1ns/1ns
interface svm_sec_if;
  import svm_pkg::*;
  logic signed [DW-1:0] sector_ref_one;
  logic signed [DW-1:0] sector_ref_two;
  logic signed [DW-1:0] sector_ref_three;
  svm_sector_t          sector;

  modport calc (output sector_ref_one, output sector_ref_two, output sector_ref_three, input sector);
  modport finder (input sector_ref_one, input sector_ref_two, input sector_ref_three, output sector);
endinterface

// *** core/svm_sector_find.sv ***
`timescale 1ns/1ns
module svm_sector_find (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // reference voltages in, sector out
  svm_sec_if.finder sec
);
  import svm_pkg::*;

  svm_sector_t sector_ff;
  svm_sector_t nxt_sector;

  // ----------------------------------------
  // sector tree
  // ----------------------------------------
  // sign bit only: zero lands on the non-negative branch
  always_comb begin
    if (!sec.sector_ref_one[DW-1]) begin
      if (!sec.sector_ref_three[DW-1]) begin
        nxt_sector = SVM_SEC_3;
      end else if (!sec.sector_ref_two[DW-1]) begin
        nxt_sector = SVM_SEC_1;
      end else begin
        nxt_sector = SVM_SEC_2;
      end
    end else begin
      if (sec.sector_ref_two[DW-1]) begin
        nxt_sector = SVM_SEC_4;
      end else if (!sec.sector_ref_three[DW-1]) begin
        nxt_sector = SVM_SEC_5;
      end else begin
        nxt_sector = SVM_SEC_6;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sector_ff <= SVM_SEC_NONE;
    end else begin
      sector_ff <= nxt_sector;
    end
  end

  assign sec.sector = sector_ff;

endmodule // svm_sector_find

// *** core/svm_duty_calc.sv ***
`timescale 1ns/1ns
module svm_duty_calc (
  // clock and reset
  input  wire logic                         clk,
  input  wire logic                         rst_n,
  // reference vector from the current controller
  input  wire logic                         in_valid,
  input  wire logic signed [svm_pkg::IW-1:0] u_alpha,
  input  wire logic signed [svm_pkg::IW-1:0] u_beta,
  input  wire logic [svm_pkg::PW-1:0]       period,
  // duty values to the pwm generator
  output logic                              out_valid,
  output logic [svm_pkg::PW-1:0]            phase_a,
  output logic [svm_pkg::PW-1:0]            phase_b,
  output logic [svm_pkg::PW-1:0]            phase_c,
  output svm_pkg::svm_sector_t              sector,
  output logic                              overmod
);
  import svm_pkg::*;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // negative ratios and ratios over one are clamped: overmodulation saturates
  function automatic logic [DW-1:0] scale_ratio(input logic signed [DW-1:0] v, input logic [PW-1:0] per);
    logic [FW-1:0]    r;
    logic [FW+PW-1:0] p;
    r = '0;
    if (v[DW-1]) begin
      r = '0;
    end else if (v > $signed({1'b0, FRAC_ONE})) begin
      r = FRAC_ONE;
    end else begin
      r = v[FW-1:0];
    end
    p = r * per;
    return p[FW+PW-1:FRAC_SHIFT];
  endfunction

  svm_sec_if sec ();

  svm_sector_find u_find (
    .clk   (clk),
    .rst_n (rst_n),
    .sec   (sec.finder)
  );

  // ----------------------------------------
  // stage 1: aux values and reference voltages
  // ----------------------------------------
  logic signed [DW-1:0] x1_ff, y1_ff, z1_ff, r1_ff, r2_ff, r3_ff;
  logic signed [DW-1:0] nxt_x1, nxt_y1, nxt_z1, nxt_r1, nxt_r2, nxt_r3;
  logic [PW-1:0]        per1_ff, nxt_per1;
  logic                 v1_ff, nxt_v1;
  logic signed [32:0]   prod_a;
  logic signed [DW-1:0] sqa;
  logic signed [DW-1:0] bx;
  logic signed [DW:0]   sum_p, sum_m;

  always_comb begin
    prod_a = u_alpha * SQRT3_Q14;
    sqa    = prod_a[SQRT3_SHIFT+DW-1:SQRT3_SHIFT];
    bx     = DW'(u_beta);
    sum_p  = (DW+1)'(bx) + (DW+1)'(sqa);
    sum_m  = (DW+1)'(bx) - (DW+1)'(sqa);
    nxt_x1 = bx;
    nxt_y1 = sum_p[DW:1];
    nxt_z1 = sum_m[DW:1];
    nxt_r1 = bx;
    nxt_r2 = -nxt_z1;
    nxt_r3 = -nxt_y1;
    nxt_per1 = period;
    nxt_v1 = in_valid;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      x1_ff   <= '0;
      y1_ff   <= '0;
      z1_ff   <= '0;
      r1_ff   <= '0;
      r2_ff   <= '0;
      r3_ff   <= '0;
      per1_ff <= '0;
      v1_ff   <= 1'b0;
    end else begin
      x1_ff   <= nxt_x1;
      y1_ff   <= nxt_y1;
      z1_ff   <= nxt_z1;
      r1_ff   <= nxt_r1;
      r2_ff   <= nxt_r2;
      r3_ff   <= nxt_r3;
      per1_ff <= nxt_per1;
      v1_ff   <= nxt_v1;
    end
  end

  assign sec.sector_ref_one   = r1_ff;
  assign sec.sector_ref_two   = r2_ff;
  assign sec.sector_ref_three = r3_ff;

  // ----------------------------------------
  // stage 2: aux values wait for the sector
  // ----------------------------------------
  logic signed [DW-1:0] x2_ff, y2_ff, z2_ff;
  logic [PW-1:0]        per2_ff;
  logic                 v2_ff;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      x2_ff   <= '0;
      y2_ff   <= '0;
      z2_ff   <= '0;
      per2_ff <= '0;
      v2_ff   <= 1'b0;
    end else begin
      x2_ff   <= x1_ff;
      y2_ff   <= y1_ff;
      z2_ff   <= z1_ff;
      per2_ff <= per1_ff;
      v2_ff   <= v1_ff;
    end
  end

  // ----------------------------------------
  // stage 3: active-vector ratios as times
  // ----------------------------------------
  logic [DW-1:0]        ta_ff, tb_ff, nxt_ta, nxt_tb;
  logic signed [DW-1:0] sel1, sel2;
  logic [PW-1:0]        per3_ff;
  svm_sector_t          sec3_ff;
  logic                 v3_ff;

  always_comb begin
    case (sec.sector)
      SVM_SEC_1: begin sel1 = x2_ff;  sel2 = -z2_ff; end
      SVM_SEC_2: begin sel1 = z2_ff;  sel2 = y2_ff;  end
      SVM_SEC_3: begin sel1 = -y2_ff; sel2 = x2_ff;  end
      SVM_SEC_4: begin sel1 = -x2_ff; sel2 = z2_ff;  end
      SVM_SEC_5: begin sel1 = -z2_ff; sel2 = -y2_ff; end
      SVM_SEC_6: begin sel1 = y2_ff;  sel2 = -x2_ff; end
      default:   begin sel1 = '0;     sel2 = '0;     end
    endcase
    nxt_ta = scale_ratio(sel1, per2_ff);
    nxt_tb = scale_ratio(sel2, per2_ff);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ta_ff   <= '0;
      tb_ff   <= '0;
      per3_ff <= '0;
      sec3_ff <= SVM_SEC_NONE;
      v3_ff   <= 1'b0;
    end else begin
      ta_ff   <= nxt_ta;
      tb_ff   <= nxt_tb;
      per3_ff <= per2_ff;
      sec3_ff <= sec.sector;
      v3_ff   <= v2_ff;
    end
  end

  // ----------------------------------------
  // stage 4: switching times, phase routing
  // ----------------------------------------
  logic signed [DW+1:0] null_t;
  logic [DW-1:0]        low_phase_time, mid_phase_time, high_phase_time;
  logic [PW-1:0]        lo, mi, hi;
  logic                 clip;
  logic [PW-1:0]        pa_ff, pb_ff, pc_ff, nxt_pa, nxt_pb, nxt_pc;
  svm_sector_t          sec4_ff;
  logic                 v4_ff, ovm_ff;

  always_comb begin
    null_t = (DW+2)'(per3_ff) - (DW+2)'(ta_ff) - (DW+2)'(tb_ff);
    clip   = null_t[DW+1];
    // overmodulation: no null time left, so low time pins at zero
    low_phase_time  = clip ? '0 : null_t[DW:1];
    mid_phase_time  = low_phase_time + ta_ff;
    high_phase_time = mid_phase_time + tb_ff;
    lo = low_phase_time[PW-1:0];
    mi = (mid_phase_time > DW'(per3_ff)) ? per3_ff : mid_phase_time[PW-1:0];
    hi = (high_phase_time > DW'(per3_ff)) ? per3_ff : high_phase_time[PW-1:0];
    case (sec3_ff)
      SVM_SEC_1: begin nxt_pa = hi; nxt_pb = mi; nxt_pc = lo; end
      SVM_SEC_2: begin nxt_pa = mi; nxt_pb = hi; nxt_pc = lo; end
      SVM_SEC_3: begin nxt_pa = lo; nxt_pb = hi; nxt_pc = mi; end
      SVM_SEC_4: begin nxt_pa = lo; nxt_pb = mi; nxt_pc = hi; end
      SVM_SEC_5: begin nxt_pa = mi; nxt_pb = lo; nxt_pc = hi; end
      SVM_SEC_6: begin nxt_pa = hi; nxt_pb = lo; nxt_pc = mi; end
      default:   begin nxt_pa = '0; nxt_pb = '0; nxt_pc = '0; end
    endcase
  end

  // outputs hold the last result between valids, pwm reloads on out_valid
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pa_ff   <= '0;
      pb_ff   <= '0;
      pc_ff   <= '0;
      sec4_ff <= SVM_SEC_NONE;
      ovm_ff  <= 1'b0;
      v4_ff   <= 1'b0;
    end else begin
      if (v3_ff) begin
        pa_ff   <= nxt_pa;
        pb_ff   <= nxt_pb;
        pc_ff   <= nxt_pc;
        sec4_ff <= sec3_ff;
        ovm_ff  <= clip;
      end
      v4_ff <= v3_ff;
    end
  end

  assign out_valid = v4_ff;
  assign phase_a   = pa_ff;
  assign phase_b   = pb_ff;
  assign phase_c   = pc_ff;
  assign sector    = sec4_ff;
  assign overmod   = ovm_ff;

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  property p_aux_x;
    in_valid |=> (x1_ff == DW'($past(u_beta))) && ((y1_ff + z1_ff - x1_ff) inside {-1, 0}) &&
      (($past(u_alpha) < 0) == (y1_ff < z1_ff));
  endproperty
  a_aux_x: assert property (p_aux_x) else $error("aux values wrong");

  property p_ref_bal;
    v1_ff |-> (r1_ff + r2_ff + r3_ff <= $signed(DW'(1))) && (r1_ff + r2_ff + r3_ff >= -$signed(DW'(1)));
  endproperty
  a_ref_bal: assert property (p_ref_bal) else $error("references not balanced");

  property p_sec_one;
    (r1_ff > 0 && r2_ff > 0 && r3_ff < 0) |=> sec.sector == SVM_SEC_1;
  endproperty
  a_sec_one: assert property (p_sec_one) else $error("sector one not found");

  property p_tree_neg;
    (r1_ff[DW-1] && r2_ff[DW-1]) |=> sec.sector == SVM_SEC_4;
  endproperty
  a_tree_neg: assert property (p_tree_neg) else $error("sector tree wrong");

  property p_zero_nonneg;
    (!r1_ff[DW-1] && r3_ff == '0) |=> sec.sector == SVM_SEC_3;
  endproperty
  a_zero_nonneg: assert property (p_zero_nonneg) else $error("zero not non-negative");

  property p_sel_low;
    (v2_ff && sec.sector == SVM_SEC_1) |=> ta_ff == scale_ratio($past(x2_ff), $past(per2_ff));
  endproperty
  a_sel_low: assert property (p_sel_low) else $error("sector one ratio wrong");

  property p_sel_high;
    (v2_ff && sec.sector == SVM_SEC_5) |=> tb_ff == scale_ratio(-$past(y2_ff), $past(per2_ff));
  endproperty
  a_sel_high: assert property (p_sel_high) else $error("sector five ratio wrong");

  property p_times;
    (v3_ff && sec3_ff == SVM_SEC_1 && !clip && high_phase_time <= DW'(per3_ff)) |=>
      (phase_a - phase_b == PW'($past(tb_ff))) && (phase_b - phase_c == PW'($past(ta_ff)));
  endproperty
  a_times: assert property (p_times) else $error("switching times wrong");

  property p_route_low;
    (v3_ff && sec3_ff == SVM_SEC_2) |=> phase_b >= phase_a && phase_a >= phase_c;
  endproperty
  a_route_low: assert property (p_route_low) else $error("sector two routing wrong");

  property p_route_high;
    (v3_ff && sec3_ff == SVM_SEC_4) |=> phase_c >= phase_b && phase_b >= phase_a;
  endproperty
  a_route_high: assert property (p_route_high) else $error("sector four routing wrong");

  property p_latency;
    in_valid |-> ##4 out_valid;
  endproperty
  a_latency: assert property (p_latency) else $error("latency not four");

  c_sec_one: cover property (v3_ff && sec3_ff == SVM_SEC_1);
  c_sec_six: cover property (v3_ff && sec3_ff == SVM_SEC_6);
  c_overmod: cover property (out_valid && overmod);
  c_b2b:     cover property (in_valid ##1 in_valid);

endmodule // svm_duty_calc

// *** verification/svm_pwm_model.sv ***
`timescale 1ns/1ns
module svm_pwm_model (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // duty values from the calculator
  input  wire logic        out_valid,
  input  wire logic [15:0] period,
  input  wire logic [15:0] phase_a,
  input  wire logic [15:0] phase_b,
  input  wire logic [15:0] phase_c,
  // bridge gates
  output logic      [2:0]  gate_top,
  output logic      [2:0]  gate_bot
);
  logic [15:0] cnt_ff;
  logic [47:0] cmp_ff;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_ff <= 16'h0000;
      cmp_ff <= 48'h0;
    end else begin
      cnt_ff <= (cnt_ff + 16'h0001 >= period) ? 16'h0000 : cnt_ff + 16'h0001;
      // compares load only with a fresh sample
      if (out_valid) begin
        cmp_ff <= {phase_a, phase_b, phase_c};
      end
    end
  end

  assign gate_top = {cnt_ff < cmp_ff[47:32], cnt_ff < cmp_ff[31:16], cnt_ff < cmp_ff[15:0]};
  // never both switches of a leg on
  assign gate_bot = ~gate_top;
endmodule  // svm_pwm_model

// *** verification/tb.sv ***
`timescale 1ns/1ns
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin n_fail++; $display("ERROR t=%0t got %h exp %h", $time, g, e); end end
module tb;
  import svm_pkg::*;
  typedef struct {logic [15:0] a, b, c; logic [2:0] sec; logic om; int take;} svm_exp_t;
  logic              clk = 1'b0;
  logic              rst_n = 1'b0;
  logic              in_valid = 1'b0;
  logic signed [15:0] u_alpha = 16'h0000;
  logic signed [15:0] u_beta = 16'h0000;
  logic [15:0]       period = 16'h03e8;
  logic              out_valid, overmod;
  logic [15:0]       phase_a, phase_b, phase_c;
  svm_sector_t       sector;
  logic [2:0]        gate_top, gate_bot;
  int                n_fail = 0, n_compared = 0, cyc = 0;
  svm_exp_t          exp_q[$];
  svm_exp_t          e, last;
  logic [15:0]       sw_al[6] = '{16'h376d, 16'h0000, 16'hc893, 16'hc893, 16'h0000, 16'h376d};
  logic [15:0]       sw_be[6] = '{16'h2000, 16'h4000, 16'h2000, 16'he000, 16'hc000, 16'he000};

  always #5 clk = ~clk;

  svm_duty_calc DUT (.clk(clk), .rst_n(rst_n), .in_valid(in_valid), .u_alpha(u_alpha), .u_beta(u_beta),
    .period(period), .out_valid(out_valid), .phase_a(phase_a), .phase_b(phase_b), .phase_c(phase_c),
    .sector(sector), .overmod(overmod));
  svm_pwm_model PWM (.clk(clk), .rst_n(rst_n), .out_valid(out_valid), .period(period), .phase_a(phase_a),
    .phase_b(phase_b), .phase_c(phase_c), .gate_top(gate_top), .gate_bot(gate_bot));

  function automatic svm_exp_t model(input logic signed [15:0] al, be, input logic [15:0] p);
    longint sqa, x, y, z, r1, r2, t1, t2, lo, mi, hi;
    svm_exp_t r;
    sqa = (longint'(al) * 28378) >>> 14;
    x = be;
    y = (x + sqa) >>> 1;
    z = (x - sqa) >>> 1;
    // refs are beta, -z, -y; zero is non-negative
    if (x >= 0) r.sec = (-y >= 0) ? 3'h3 : ((-z >= 0) ? 3'h1 : 3'h2);
    else r.sec = (-z < 0) ? 3'h4 : ((-y >= 0) ? 3'h5 : 3'h6);
    case (r.sec)
      3'h1: {r1, r2} = {x, -z};
      3'h2: {r1, r2} = {z, y};
      3'h3: {r1, r2} = {-y, x};
      3'h4: {r1, r2} = {-x, z};
      3'h5: {r1, r2} = {-z, -y};
      default: {r1, r2} = {y, -x};
    endcase
    r1 = (r1 < 0) ? 0 : ((r1 > 32768) ? 32768 : r1);
    r2 = (r2 < 0) ? 0 : ((r2 > 32768) ? 32768 : r2);
    t1 = (r1 * p) >>> 15;
    t2 = (r2 * p) >>> 15;
    lo = p - t1 - t2;
    r.om = lo < 0;
    lo = (lo < 0) ? 0 : lo >>> 1;
    mi = (lo + t1 > p) ? p : lo + t1;
    hi = (mi + t2 > p) ? p : mi + t2;
    case (r.sec)
      3'h1: {r.a, r.b, r.c} = {hi[15:0], mi[15:0], lo[15:0]};
      3'h2: {r.a, r.b, r.c} = {mi[15:0], hi[15:0], lo[15:0]};
      3'h3: {r.a, r.b, r.c} = {lo[15:0], hi[15:0], mi[15:0]};
      3'h4: {r.a, r.b, r.c} = {lo[15:0], mi[15:0], hi[15:0]};
      3'h5: {r.a, r.b, r.c} = {mi[15:0], lo[15:0], hi[15:0]};
      default: {r.a, r.b, r.c} = {hi[15:0], lo[15:0], mi[15:0]};
    endcase
    return r;
  endfunction

  // ----------------------------------------
  // output monitor, exact latency
  // ----------------------------------------
  always @(posedge clk) begin
    cyc = cyc + 1;
    #1;
    if (out_valid === 1'b1) begin
      if (exp_q.size() == 0) `CHK(out_valid, 1'b0)
      else begin
        e = exp_q.pop_front();
        last = e;
        // read one edge before the one that samples out_valid high
        `CHK(cyc + 1 - e.take, LATENCY)
        `CHK({phase_a, phase_b, phase_c}, {e.a, e.b, e.c})
        `CHK(sector, e.sec)
        `CHK(overmod, e.om)
      end
    end
  end

  task automatic summarize();
    $display("compared %0d mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // in_valid stays high so back-to-back samples never toggle it in one step
  task automatic put(input logic [15:0] al, be, p);
    exp_q.push_back(model(al, be, p));
    exp_q[$].take = cyc + 1;
    {in_valid, u_alpha, u_beta, period} = {1'b1, al, be, p};
    @(posedge clk);
    #1;
  endtask

  task automatic drain();
    in_valid = 1'b0;
    for (int i = 0; i < 20 && exp_q.size() > 0; i++) @(posedge clk);
    #1;
    if (exp_q.size() > 0) begin
      n_fail++;
      summarize();
    end
  endtask

  task automatic t_reset_zero();
    `CHK({out_valid, phase_a, phase_b, phase_c, sector, overmod}, 53'h0)
  endtask

  task automatic t_sweep_single();
    for (int i = 0; i < 6; i++) begin
      put(sw_al[i], sw_be[i], 16'h03e8);
      drain();
      `CHK(sector, 3'(i + 1))
    end
  endtask

  task automatic t_sweep_b2b();
    for (int i = 5; i >= 0; i--) put(sw_al[i], sw_be[i], 16'h0fa0);
    drain();
  endtask

  task automatic t_edges();
    put(16'h0000, 16'h0000, 16'h03e9);
    put(16'h4000, 16'h0000, 16'h03e8);
    put(16'h7fff, 16'h7fff, 16'h03e8);
    put(16'h8000, 16'h0000, 16'hffff);
    put(16'h0000, 16'h8000, 16'hffff);
    drain();
  endtask

  task automatic t_hold();
    repeat (6) @(posedge clk);
    #1;
    `CHK({phase_a, phase_b, phase_c, sector}, {last.a, last.b, last.c, last.sec})
  endtask

  // gate on-time over one full pwm period must equal the compare value
  task automatic t_pwm();
    logic [15:0] on_a, on_b, on_c;
    {on_a, on_b, on_c} = 48'h0;
    put(16'h376d, 16'h2000, 16'h0064);
    drain();
    for (int i = 0; i < 100; i++) begin
      @(posedge clk);
      #1;
      on_a = on_a + 16'(gate_top[2]);
      on_b = on_b + 16'(gate_top[1]);
      on_c = on_c + 16'(gate_top[0]);
      `CHK(gate_bot, ~gate_top)
    end
    `CHK({on_a, on_b, on_c}, {last.a, last.b, last.c})
  endtask

  task automatic t_reset_mid();
    put(16'h376d, 16'h2000, 16'h03e8);
    in_valid = 1'b0;
    @(posedge clk);
    #1;
    rst_n = 1'b0;
    exp_q.delete();
    #2;
    t_reset_zero();
    repeat (5) @(posedge clk);
    #1;
    rst_n = 1'b1;
    repeat (6) @(posedge clk);
    #1;
    t_reset_zero();
  endtask

  initial begin
    repeat (5) @(posedge clk);
    #1;
    t_reset_zero();
    rst_n = 1'b1;
    t_sweep_single();
    t_sweep_b2b();
    t_edges();
    t_hold();
    t_pwm();
    t_reset_mid();
    t_sweep_b2b();
    summarize();
  end
endmodule  // tb
